//--- shared/rtd_regs_pkg.sv
// constants and types for the rtd input register bank
package rtd_regs_pkg;
  localparam int ADDR_W = 4;
  // register offsets are avalon word indexes
  localparam logic [3:0] IDX_POINT = 4'hc;
  localparam logic [3:0] IDX_CFG = 4'hd;
  localparam logic [3:0] IDX_SCALE34 = 4'he;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'h0;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h1;
  localparam logic [3:0] IDX_DIAG_DATA = 4'h2;
  localparam int CFG_CONFIGURE = 0;
  localparam int CFG_FORCE_ERR = 1;
  localparam int CFG_POINT_FAULT = 2;
  localparam int CFG_CARD_TROUBLE = 3;
  localparam int CFG_WARMING = 4;
  localparam int CFG_MAINS_50HZ = 5;
  localparam int CFG_TRACK_EN = 6;
  localparam int CFG_DIAG = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] SCALE_RESET = 8'h00;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // interrupt events
  localparam int IRQ_N = 4;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_POINT = 1;
  localparam int IRQ_SYNC = 2;
  localparam int IRQ_READY = 3;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int WARMUP_MS = 100;
  localparam int WARMUP_CYC = WARMUP_MS * (CLK_HZ / 1000);
  localparam int APPLY_US = 10;
  localparam int APPLY_CYC = APPLY_US * (CLK_HZ / 1_000_000);
  localparam int WDOG_MS = 1000;
  localparam int WDOG_CYC = WDOG_MS * (CLK_HZ / 1000);
  localparam logic [31:0] CNT_ONE = 32'h00000001;
  localparam logic [31:0] CNT_ZERO = 32'h00000000;

  typedef struct packed {
    logic [7:0] ch1;
    logic [7:0] ch2;
    logic [7:0] ch3;
    logic [7:0] ch4;
  } scales_s;

  typedef struct packed {
    logic diag;
    logic track_en;
    logic mains_50hz;
    logic force_err;
    logic configure;
  } cfg_s;

  typedef enum logic [2:0] {
    ST_WARM = 3'b001,
    ST_APPLY = 3'b010,
    ST_RUN = 3'b100
  } phase_e;
endpackage

//--- verilog/rtd_input_config_status_regs.sv
// avalon-mm register bank of the four channel rtd input module
`timescale 1ns/100ps
// Behaviour
// - word 13 writes configuration, reads status
// - config bit 0 configures; status bit0 shows
// - bit 1 forces error; status shows error
// - status bit 2 when any channel fault
// - status bit 3 during card failure
// - status bit 4 during warmup or configuring
// - bit 5 selects 60/50 hz, read back
// - bit 6 enables tracking, read back
// - status bit 7 sync fault while tracking
// - bit 7 makes bits 0-6 memory address
// - word 13 high byte channel 2 scale
// - word 14 holds channel 3 and 4 scales
// - word 12 low byte per channel test failures
// - point flags read 1 while fault present
// - word 12 high byte channel 1 scale
// - internal fault on forced error or watchdog
module rtd_input_config_status_regs #(
  parameter int WARMUP_CYCLES = rtd_regs_pkg::WARMUP_CYC,
  parameter int WDOG_CYCLES = rtd_regs_pkg::WDOG_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [3:0] zero_fail_in,
  input wire logic [3:0] loop_fail_in,
  input wire logic card_fail_in,
  input wire logic sync_missing_in,
  input wire logic sync_unreasonable_in,
  input wire logic [15:0] diag_mem_data_in,
  output logic [6:0] diag_mem_addr_out,
  output logic diag_mode_out,
  output logic mains_50hz_out,
  output logic track_en_out,
  output logic internal_fault_out,
  output logic irq_out
);
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // pin inputs through two flip-flops
  localparam int PIN_W = 27;
  logic [PIN_W-1:0] pin_raw, pin_s1_q, pin_s2_q;
  assign pin_raw = {diag_mem_data_in, sync_unreasonable_in, sync_missing_in,
                    card_fail_in, zero_fail_in, loop_fail_in[2:0],
                    loop_fail_in[3]};
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end
  wire [3:0] loop_fail = {pin_s2_q[0], pin_s2_q[3:1]};
  wire [3:0] zero_fail = pin_s2_q[7:4];
  wire card_fail = pin_s2_q[8];
  wire sync_missing = pin_s2_q[9];
  wire sync_bad = pin_s2_q[10];
  wire [15:0] diag_data = pin_s2_q[26:11];

  // one-cycle answer: waitrequest high on the first cycle of a request
  logic ack_q;
  wire req = (avs_read_in || avs_write_in) && !ack_q;
  wire take = (avs_read_in || avs_write_in) && ack_q;
  wire wr = avs_write_in && ack_q;
  wire rd = avs_read_in && ack_q;
  wire lo_en = avs_byteenable_in[0];
  wire hi_en = avs_byteenable_in[1];

  function automatic logic sel(input logic [3:0] a, input logic [3:0] idx);
    sel = (a == idx);
  endfunction

  wire wr_point = wr && sel(avs_address_in, rtd_regs_pkg::IDX_POINT);
  wire wr_cfg = wr && sel(avs_address_in, rtd_regs_pkg::IDX_CFG);
  wire wr_s34 = wr && sel(avs_address_in, rtd_regs_pkg::IDX_SCALE34);
  wire wr_ist = wr && sel(avs_address_in, rtd_regs_pkg::IDX_IRQ_STATUS);
  wire wr_imk = wr && sel(avs_address_in, rtd_regs_pkg::IDX_IRQ_MASK);
  wire rd_point = rd && sel(avs_address_in, rtd_regs_pkg::IDX_POINT);
  wire rd_cfg = rd && sel(avs_address_in, rtd_regs_pkg::IDX_CFG);
  wire rd_s34 = rd && sel(avs_address_in, rtd_regs_pkg::IDX_SCALE34);

  rtd_regs_pkg::cfg_s cfg_q;
  rtd_regs_pkg::scales_s scales_q;
  logic [3:0] irq_mask_q, irq_stat_q;
  logic configured_q;
  rtd_regs_pkg::phase_e phase_q, phase_d;
  logic [31:0] warm_cnt_q, wdog_cnt_q;
  logic wdog_exp_q;

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end else begin
      ack_q <= req;
      avs_waitrequest_out <= !req;
    end
  end

  // configuration low byte and scale codes
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q <= '0;
      scales_q <= '0;
      irq_mask_q <= rtd_regs_pkg::IRQ_RESET;
    end else begin
      if (wr_cfg && lo_en) begin
        cfg_q <= {avs_writedata_in[rtd_regs_pkg::CFG_DIAG],
                  avs_writedata_in[rtd_regs_pkg::CFG_TRACK_EN],
                  avs_writedata_in[rtd_regs_pkg::CFG_MAINS_50HZ],
                  avs_writedata_in[rtd_regs_pkg::CFG_FORCE_ERR],
                  avs_writedata_in[rtd_regs_pkg::CFG_CONFIGURE]};
      end
      if (wr_cfg && hi_en) begin
        scales_q.ch2 <= avs_writedata_in[15:8];
      end
      if (wr_point && hi_en) begin
        scales_q.ch1 <= avs_writedata_in[15:8];
      end
      if (wr_s34 && lo_en) begin
        scales_q.ch3 <= avs_writedata_in[7:0];
      end
      if (wr_s34 && hi_en) begin
        scales_q.ch4 <= avs_writedata_in[15:8];
      end
      if (wr_imk && lo_en) begin
        irq_mask_q <= avs_writedata_in[3:0];
      end
    end
  end

  // diagnostic address held in bits 0..6 while diag bit set
  logic [6:0] diag_addr_q;
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      diag_addr_q <= 7'h00;
    end else if (wr_cfg && lo_en && avs_writedata_in[7]) begin
      diag_addr_q <= avs_writedata_in[6:0];
    end
  end

  // warm-up and configuration apply sequencing
  wire warm_done = (warm_cnt_q == rtd_regs_pkg::CNT_ZERO);
  wire cfg_write = wr_cfg && lo_en && !avs_writedata_in[7];
  wire next_conf = (wr_cfg && lo_en) ?
                   avs_writedata_in[rtd_regs_pkg::CFG_CONFIGURE] :
                   cfg_q.configure;
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      rtd_regs_pkg::ST_WARM: begin
        if (warm_done) begin
          phase_d = rtd_regs_pkg::ST_RUN;
        end
      end
      rtd_regs_pkg::ST_APPLY: begin
        if (warm_done) begin
          phase_d = rtd_regs_pkg::ST_RUN;
        end
      end
      rtd_regs_pkg::ST_RUN: begin
        if (cfg_write) begin
          phase_d = rtd_regs_pkg::ST_APPLY;
        end
      end
      default: phase_d = rtd_regs_pkg::ST_WARM;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      phase_q <= rtd_regs_pkg::ST_WARM;
      warm_cnt_q <= 32'(WARMUP_CYCLES);
      configured_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      if (phase_q == rtd_regs_pkg::ST_RUN && cfg_write) begin
        warm_cnt_q <= 32'(rtd_regs_pkg::APPLY_CYC);
      end else if (!warm_done) begin
        warm_cnt_q <= warm_cnt_q - rtd_regs_pkg::CNT_ONE;
      end
      if (phase_d == rtd_regs_pkg::ST_RUN && phase_q != rtd_regs_pkg::ST_RUN)
      begin
        configured_q <= next_conf;
      end else if (cfg_write && !avs_writedata_in[0]) begin
        configured_q <= 1'b0;
      end
    end
  end

  // communication watchdog restarted by any access
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wdog_cnt_q <= 32'(WDOG_CYCLES);
      wdog_exp_q <= 1'b0;
    end else if (take) begin
      wdog_cnt_q <= 32'(WDOG_CYCLES);
      wdog_exp_q <= 1'b0;
    end else if (wdog_cnt_q != rtd_regs_pkg::CNT_ZERO) begin
      wdog_cnt_q <= wdog_cnt_q - rtd_regs_pkg::CNT_ONE;
    end else if (configured_q) begin
      wdog_exp_q <= 1'b1;
    end
  end

  wire [7:0] point_flags;
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_pt
      assign point_flags[2*ch] = zero_fail[ch];
      assign point_flags[2*ch+1] = loop_fail[ch];
    end
  endgenerate

  wire int_fault = cfg_q.force_err || wdog_exp_q;
  wire point_fault = |point_flags;
  wire sync_fault = cfg_q.track_en && (sync_missing || sync_bad);
  wire warming = phase_q != rtd_regs_pkg::ST_RUN;
  wire [7:0] status_lo = {sync_fault, cfg_q.track_en, cfg_q.mains_50hz,
                          warming, card_fail, point_fault, int_fault,
                          configured_q};

  // sticky interrupt events, set wins over write-one clear
  wire [3:0] irq_ev = {configured_q && !warming, sync_fault, point_fault,
                       int_fault};
  wire [3:0] irq_clr = (wr_ist && lo_en) ? avs_writedata_in[3:0] : 4'h0;
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_stat_q <= rtd_regs_pkg::IRQ_RESET;
      irq_out <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
      irq_out <= |(irq_stat_q & irq_mask_q);
    end
  end

  logic [15:0] rd_word;
  always_comb begin
    case (avs_address_in)
      rtd_regs_pkg::IDX_POINT: rd_word = {scales_q.ch1, point_flags};
      rtd_regs_pkg::IDX_CFG: rd_word = {scales_q.ch2, status_lo};
      rtd_regs_pkg::IDX_SCALE34: rd_word = {scales_q.ch4, scales_q.ch3};
      rtd_regs_pkg::IDX_IRQ_STATUS: rd_word = {12'h000, irq_stat_q};
      rtd_regs_pkg::IDX_IRQ_MASK: rd_word = {12'h000, irq_mask_q};
      rtd_regs_pkg::IDX_DIAG_DATA: rd_word = diag_data;
      default: rd_word = rtd_regs_pkg::ZERO16;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      avs_readdata_out <= 32'h00000000;
      diag_mem_addr_out <= 7'h00;
      diag_mode_out <= 1'b0;
      mains_50hz_out <= 1'b0;
      track_en_out <= 1'b0;
      internal_fault_out <= 1'b0;
    end else begin
      if (req && avs_read_in) begin
        avs_readdata_out <= {16'h0000, rd_word};
      end
      diag_mem_addr_out <= diag_addr_q;
      diag_mode_out <= cfg_q.diag;
      mains_50hz_out <= cfg_q.mains_50hz;
      track_en_out <= cfg_q.track_en;
      internal_fault_out <= int_fault;
    end
  end

  a_wait_one: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    (avs_read_in || avs_write_in) && !ack_q |=> !avs_waitrequest_out)
    else $error("answer not one cycle after request");
  a_force_err: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    cfg_q.force_err |=> internal_fault_out)
    else $error("forced error not shown");
  a_point_or: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    status_lo[2] == (|point_flags))
    else $error("point fault bit wrong");
  a_sync_gate: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    !cfg_q.track_en |-> !status_lo[7])
    else $error("sync fault without tracking");
  a_ch2_scale: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    wr_cfg && hi_en |=> scales_q.ch2 == $past(avs_writedata_in[15:8]))
    else $error("ch2 scale not stored");
  a_ch1_scale: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    wr_point && hi_en |=> scales_q.ch1 == $past(avs_writedata_in[15:8]))
    else $error("ch1 scale not stored");
  a_warm_flag: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    phase_q == rtd_regs_pkg::ST_RUN && cfg_write |=> status_lo[4])
    else $error("warming not set on configure");
  a_unconf_warm: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    warming && !$past(configured_q) |-> !configured_q)
    else $error("configured during warmup");
  a_mains_out: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    wr_cfg && lo_en |=> ##1 mains_50hz_out == $past(avs_writedata_in[5], 2))
    else $error("mains select not applied");

  a_read_upper: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    rd |-> avs_readdata_out[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_status_read: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    rd_cfg |-> avs_readdata_out[7:0] == $past(status_lo))
    else $error("status byte not returned");
  a_ch2_read: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    rd_cfg |-> avs_readdata_out[15:8] == $past(scales_q.ch2))
    else $error("ch2 scale not read back");
  a_point_read: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    rd_point |-> avs_readdata_out[7:0] == $past(point_flags))
    else $error("point flags not returned");
  a_ch1_read: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    rd_point |-> avs_readdata_out[15:8] == $past(scales_q.ch1))
    else $error("ch1 scale not read back");
  a_ch3_read: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    rd_s34 |-> avs_readdata_out[7:0] == $past(scales_q.ch3))
    else $error("ch3 scale not read back");
  a_ch4_read: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    rd_s34 |-> avs_readdata_out[15:8] == $past(scales_q.ch4))
    else $error("ch4 scale not read back");
  a_conf_store: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    wr_cfg && lo_en |=> cfg_q.configure == $past(avs_writedata_in[0]))
    else $error("configure bit not stored");
  a_track_out: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    track_en_out == $past(cfg_q.track_en))
    else $error("tracking output not following");
  a_diag_addr: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    wr_cfg && lo_en && avs_writedata_in[7]
    |=> diag_addr_q == $past(avs_writedata_in[6:0]))
    else $error("diag address not loaded");
  a_card_sync: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    $past(rst_n_q, 2) |-> status_lo[3] == $past(card_fail_in, 2))
    else $error("card trouble not two cycles late");
  a_loop_sync: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    $past(rst_n_q, 2) |-> loop_fail == $past(loop_fail_in, 2))
    else $error("loop flags not two cycles late");
  a_diag_sync: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    $past(rst_n_q, 2) |-> diag_data == $past(diag_mem_data_in, 2))
    else $error("diag data not two cycles late");
  a_wdog_fire: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    configured_q && !take && wdog_cnt_q == rtd_regs_pkg::CNT_ZERO
    |=> wdog_exp_q)
    else $error("watchdog did not expire");
  a_wdog_clear: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    take |=> !wdog_exp_q)
    else $error("access did not clear watchdog");
  a_irq_set: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    |irq_ev |=> (irq_stat_q & $past(irq_ev)) == $past(irq_ev))
    else $error("event lost against clear");
  a_conf_rise: assert property (@(posedge clk_in)
    disable iff (!rst_n_q)
    $rose(configured_q) |-> cfg_q.configure && !warming)
    else $error("configured without config bit");
endmodule

//--- sim/io_controller_model.sv
// avalon-mm master standing in for the system i/o controller
`timescale 1ns/100ps
module io_controller_model (
  input wire logic clk_in,
  input wire logic [31:0] rdata_in,
  input wire logic wait_in,
  output logic [3:0] addr_out,
  output logic rd_out,
  output logic wr_out,
  output logic [31:0] wdata_out,
  output logic [3:0] be_out
);
  initial begin
    addr_out = 4'h0;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 32'h00000000;
    be_out = 4'h0;
  end
  // one access: held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [3:0] a,
      input logic [15:0] d, input logic [3:0] b, output logic [31:0] q);
    @(posedge clk_in);
    addr_out <= a;
    wr_out <= w;
    rd_out <= !w;
    wdata_out <= {16'h0000, d};
    be_out <= b;
    @(posedge clk_in);
    while (wait_in !== 1'b0) @(posedge clk_in);
    q = rdata_in;
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    // released data bus shows the inverted write data
    wdata_out <= ~wdata_out;
  endtask
endmodule

//--- sim/rtd_input_config_status_regs_tb_top.sv
// self-checking bench of the rtd input register bank
`timescale 1ns/100ps
module rtd_input_config_status_regs_tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] zf, lf, addr, be;
  logic card, smiss, sunr, rdv, wrv, wreq, dmode, m50, trk, ifault, irq;
  logic [15:0] dmem;
  logic [31:0] wd, rdata, rq, junk, s, seed = 32'h27156c04;
  logic [6:0] dma;
  logic [7:0] c2;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  io_controller_model io_controller_model_i (.clk_in(clk),
    .rdata_in(rdata), .wait_in(wreq), .addr_out(addr), .rd_out(rdv),
    .wr_out(wrv), .wdata_out(wd), .be_out(be));
  rtd_input_config_status_regs #(.WARMUP_CYCLES(20), .WDOG_CYCLES(50))
    rtd_input_config_status_regs_i (.clk_in(clk), .arst_n_in(arst_n),
    .avs_address_in(addr), .avs_read_in(rdv), .avs_write_in(wrv),
    .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .zero_fail_in(zf), .loop_fail_in(lf), .card_fail_in(card),
    .sync_missing_in(smiss), .sync_unreasonable_in(sunr),
    .diag_mem_data_in(dmem), .diag_mem_addr_out(dma),
    .diag_mode_out(dmode), .mains_50hz_out(m50), .track_en_out(trk),
    .internal_fault_out(ifault), .irq_out(irq));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected point status byte: zero test even bits, loop test odd bits
  function automatic logic [31:0] pt(input logic [3:0] z, input logic [3:0] l);
    pt = 32'h00000000;
    for (int n = 0; n < 4; n++) begin
      pt[2*n] = z[n];
      pt[2*n+1] = l[n];
    end
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    io_controller_model_i.xfer(1'b1, a, d, 4'h3, junk);
  endtask
  task automatic rd(input logic [3:0] a);
    io_controller_model_i.xfer(1'b0, a, 16'h0000, 4'h3, rq);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    {zf, lf, card, smiss, sunr, dmem} <= '0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(4'hd); chk(rq, 32'h10);
    rd(4'hc); chk(rq, 32'h0);
    rd(4'he); chk(rq, 32'h0);
    repeat (25) @(posedge clk);
    rd(4'hd); chk(rq, 32'h0);
    s = rnd();
    c2 = s[7:0];
    wr(4'hd, {c2, 8'h21});
    rd(4'hd); chk(rq, {16'h0, c2, 8'h30});
    for (int n = 0; n < 80 && rq[0] !== 1'b1; n++) begin
      repeat (8) @(posedge clk);
      rd(4'hd);
    end
    chk(rq, {16'h0, c2, 8'h21});
    chk({31'h0, m50}, 32'h1);
    repeat (60) @(posedge clk);
    chk({31'h0, ifault}, 32'h1);
    wr(4'hd, {c2, 8'h23});
    repeat (3) @(posedge clk);
    chk({31'h0, ifault}, 32'h1);
    rd(4'hd); chk(rq & 32'h2, 32'h2);
    wr(4'hd, {c2, 8'h21});
    rd(4'hd); chk(rq & 32'h2, 32'h0);
    for (int i = 0; i < 4; i++) begin
      s = rnd();
      wr(4'he, s[15:0]);
      rd(4'he); chk(rq, {16'h0, s[15:0]});
      wr(4'hc, {s[31:24], 8'h00});
      rd(4'hc); chk(rq, {16'h0, s[31:24], 8'h00});
    end
    io_controller_model_i.xfer(1'b1, 4'he, 16'hffff, 4'h1, junk);
    rd(4'he); chk(rq, {16'h0, s[15:8], 8'hff});
    for (int i = 0; i < 5; i++) begin
      s = (i == 4) ? 32'h0 : rnd();
      zf <= s[3:0];
      lf <= s[7:4];
      repeat (4) @(posedge clk);
      rd(4'hc); chk(rq & 32'hff, pt(s[3:0], s[7:4]));
      rd(4'hd); chk({31'h0, rq[2]}, {31'h0, |s[7:0]});
    end
    rd(4'h0); chk({31'h0, rq[1]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(4'h1, 16'h0002);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(4'h0, 16'h0002);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(4'h0); chk({31'h0, rq[1]}, 32'h0);
    for (int i = 1; i >= 0; i--) begin
      card <= i[0];
      repeat (4) @(posedge clk);
      rd(4'hd); chk({31'h0, rq[3]}, i);
    end
    wr(4'hd, {c2, 8'h61});
    for (int i = 0; i < 4; i++) begin
      smiss <= (i == 0 || i == 3);
      sunr <= (i == 1);
      if (i == 3) wr(4'hd, {c2, 8'h01});
      repeat (4) @(posedge clk);
      rd(4'hd);
      chk(rq & 32'hc0, (i == 3) ? 32'h0 : (i == 2) ? 32'h40 : 32'hc0);
      chk({31'h0, trk}, {31'h0, i != 3});
      chk({31'h0, m50}, {31'h0, i != 3});
      chk({31'h0, rq[5]}, {31'h0, i != 3});
    end
    smiss <= 1'b0;
    s = rnd();
    dmem <= s[15:0];
    wr(4'hd, {c2, 1'b1, s[22:16]});
    repeat (3) @(posedge clk);
    chk({25'h0, dma}, {25'h0, s[22:16]});
    chk({31'h0, dmode}, 32'h1);
    rd(4'h2); chk(rq, {16'h0, s[15:0]});
    wr(4'h5, 16'hffff);
    rd(4'h5); chk(rq, 32'h0);
    wrap_up();
  end
endmodule
